// ==== hw/uart_lf_map.svh ====
// Register offsets, field positions, reset values and timing counts for the
// line-format and loop-back channel block. Included by the package and modules.
`ifndef UART_LF_MAP_SVH
`define UART_LF_MAP_SVH

// Byte addresses on the APB register bus.
`define LF_OFF_DATA 8'h00
`define LF_OFF_IEN 8'h04
`define LF_OFF_LFC 8'h0C
`define LF_OFF_MLC 8'h10
`define LF_OFF_MST 8'h18

// Line-format field positions.
`define LFC_DLAB 7
`define LFC_BREAK 6
`define LFC_STICK 5
`define LFC_EVEN 4
`define LFC_PAREN 3
`define LFC_STOP 2
`define LFC_WLEN_HI 1

// Modem-control field positions.
`define MLC_LOOP 4
`define MLC_OUT2 3
`define MLC_OUT1 2
`define MLC_RTS 1
`define MLC_DTR 0
`define MLC_USED_MASK 8'h1F

// Interrupt-enable field positions.
`define IEN_THRE 1
`define IEN_MSTAT 3

// Reset values.
`define LFC_RESET 8'h00
`define MLC_RESET 8'h00
`define IEN_RESET 4'h0
`define DIV_RESET 16'h0000

// Sub-bit ticks: one bit is 16 baud ticks; stop ends at these tick counts.
`define TICK_BIT_LAST 5'h0F
`define TICK_STOP_HALF_LAST 5'h17
`define TICK_STOP_TWO_LAST 5'h1F

`endif

// ==== hw/uart_lf_pkg.sv ====
// Types shared by the line-format and loop-back channel block.
// Assumes the map header is on the include path.
`include "uart_lf_map.svh"

package uart_lf_pkg;

    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PARITY = 5'b01000,
        TX_STOP = 5'b10000
    } tx_state_t;

    typedef struct packed {
        logic [7:0] lfc;
        logic [7:0] mlc;
        logic [3:0] ien;
        logic [15:0] div;
        logic [7:0] thr;
        logic thr_full;
        tx_state_t state;
        logic [7:0] shift;
        logic [2:0] bit_idx;
        logic [4:0] sub;
        logic [15:0] baud_cnt;
        logic par;
        logic tx_bit;
        logic [3:0] mst_prev;
        logic [3:0] mst_delta;
        logic [3:0] mst_shown;
        logic [31:0] prdata;
    } lf_state_t;

endpackage : uart_lf_pkg

// ==== hw/loop_route_if.sv ====
// Carrier between the channel core and its loop-back pin router.
// Assumes both ends are combinational towards each other within one clock.
`timescale 1ns/1ps
`default_nettype none

interface loop_route_if;
    logic loop;
    logic tx_int;
    logic rts;
    logic dtr;
    logic out1;
    logic out2;
    logic rx_int;
    logic ms_cts;
    logic ms_dsr;
    logic ms_ri;
    logic ms_cd;

    modport core (output loop, tx_int, rts, dtr, out1, out2,
                  input rx_int, ms_cts, ms_dsr, ms_ri, ms_cd);
    modport router (input loop, tx_int, rts, dtr, out1, out2,
                    output rx_int, ms_cts, ms_dsr, ms_ri, ms_cd);
endinterface : loop_route_if

`default_nettype wire

// ==== hw/loop_router.sv ====
// Pin router: connects the core to the pins, or in loop-back folds outputs
// back to inputs. Assumes pin inputs are synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none

module loop_router (
    // Core side.
    loop_route_if.router rt,
    // Serial and modem pins, modem pins active low.
    input wire logic rx_pin,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic cd_n,
    output logic tx_pin,
    output logic rts_n,
    output logic dtr_n,
    output logic out1_n,
    output logic out2_n
);

    always_comb begin
        if (rt.loop) begin
            // Outputs go inactive and the inputs are fed from the core.
            tx_pin = 1'b1;
            rts_n = 1'b1;
            dtr_n = 1'b1;
            out1_n = 1'b1;
            out2_n = 1'b1;
            rt.rx_int = rt.tx_int;
            rt.ms_cts = rt.rts;
            rt.ms_dsr = rt.dtr;
            rt.ms_ri = rt.out1;
            rt.ms_cd = rt.out2;
        end else begin
            tx_pin = rt.tx_int;
            rts_n = ~rt.rts;
            dtr_n = ~rt.dtr;
            out1_n = ~rt.out1;
            out2_n = ~rt.out2;
            rt.rx_int = rx_pin;
            rt.ms_cts = ~cts_n;
            rt.ms_dsr = ~dsr_n;
            rt.ms_ri = ~ri_n;
            rt.ms_cd = ~cd_n;
        end
    end

endmodule : loop_router

`default_nettype wire

// ==== hw/uart_line_format_loopback.sv ====
// One serial channel: APB registers for line format and modem control, a
// transmitter that obeys the format, modem status and a loop-back router.
// Assumes APB master in pclk domain and pin inputs synchronous to pclk.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_lf_map.svh"

// Functional notes
// - Line-format bit 7 set opens the divisor latch; reset leaves it closed.
// - Line-format bit 6 holds transmit low as a break until cleared.
// - Bits 5:3 select none, odd, even, forced one or forced zero parity.
// - Bit 2 set gives 1.5 stop bits for 5-bit words, else 2.
// - Bits 1:0 select word length 5 to 8 for transmit.
// - Modem-control bits 7:5 are unused and read as zero.
// - Modem-control bit 4 enters loop-back and detaches serial and modem pins.
// - In loop-back transmit data and modem outputs return internally.
// - The transmit interrupt behaves the same in loop-back.
// - In loop-back modem interrupts come from modem-control bits 3:0, still enabled.
// - Bit 3 drives second user output and interrupt enable; loop carrier follows.
// - Bit 2 drives first user output; in loop-back it supplies the internal ring signal.
module uart_line_format_loopback
    import uart_lf_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial and modem pins.
    input wire logic rx_pin,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic cd_n,
    output logic tx_pin,
    output logic rts_n,
    output logic dtr_n,
    output logic out1_n,
    output logic out2_n,
    // Interrupt pin with its output enable, and the internal receive line.
    output logic irq,
    output logic irq_oe,
    output logic rx_line
);

    lf_state_t s_ff;
    lf_state_t nxt_s;
    loop_route_if rt ();

    logic setup;
    logic access;
    logic mapped;
    logic dlab;
    logic [2:0] wl_last;
    logic [4:0] stop_last;
    logic [7:0] wmask;
    logic tick;
    logic bit_end;
    logic [3:0] ms_now;
    logic [3:0] ms_chg;

    loop_router u_router (
        .rt(rt.router),
        .rx_pin(rx_pin),
        .cts_n(cts_n),
        .dsr_n(dsr_n),
        .ri_n(ri_n),
        .cd_n(cd_n),
        .tx_pin(tx_pin),
        .rts_n(rts_n),
        .dtr_n(dtr_n),
        .out1_n(out1_n),
        .out2_n(out2_n)
    );

    assign rt.loop = s_ff.mlc[`MLC_LOOP];
    assign rt.tx_int = s_ff.lfc[`LFC_BREAK] ? 1'b0 : s_ff.tx_bit;
    assign rt.rts = s_ff.mlc[`MLC_RTS];
    assign rt.dtr = s_ff.mlc[`MLC_DTR];
    assign rt.out1 = s_ff.mlc[`MLC_OUT1];
    assign rt.out2 = s_ff.mlc[`MLC_OUT2];
    assign rx_line = rt.rx_int;

    assign setup = psel && !penable;
    assign access = psel && penable && ce;
    assign pready = ce;
    assign dlab = s_ff.lfc[`LFC_DLAB];
    assign mapped = (paddr == `LF_OFF_DATA) || (paddr == `LF_OFF_IEN) ||
                    (paddr == `LF_OFF_LFC) || (paddr == `LF_OFF_MLC) ||
                    (paddr == `LF_OFF_MST);
    assign pslverr = psel && penable && !mapped;
    assign prdata = s_ff.prdata;

    // Word length, stop length and data mask follow the format register.
    assign wl_last = {1'b1, s_ff.lfc[`LFC_WLEN_HI:0]};
    assign wmask = 8'hFF >> (3'h3 - {1'b0, s_ff.lfc[`LFC_WLEN_HI:0]});

    always_comb begin
        if (!s_ff.lfc[`LFC_STOP]) begin
            stop_last = `TICK_BIT_LAST;
        end else if (s_ff.lfc[`LFC_WLEN_HI:0] == 2'b00) begin
            stop_last = `TICK_STOP_HALF_LAST;
        end else begin
            stop_last = `TICK_STOP_TWO_LAST;
        end
    end

    assign tick = (s_ff.div != 16'h0000) && (s_ff.baud_cnt == s_ff.div - 16'h0001);
    assign bit_end = tick && (s_ff.sub == `TICK_BIT_LAST);

    // Modem status as {cd, ri, dsr, cts}; in loop-back these are the control bits.
    assign ms_now = {rt.ms_cd, rt.ms_ri, rt.ms_dsr, rt.ms_cts};
    assign ms_chg = {s_ff.mst_prev[3] ^ ms_now[3],
                     s_ff.mst_prev[2] & ~ms_now[2],
                     s_ff.mst_prev[1] ^ ms_now[1],
                     s_ff.mst_prev[0] ^ ms_now[0]};

    // Same interrupt logic in both modes; second user output enables the pin.
    assign irq = (s_ff.ien[`IEN_THRE] && !s_ff.thr_full) ||
                 (s_ff.ien[`IEN_MSTAT] && (s_ff.mst_delta != 4'h0));
    assign irq_oe = s_ff.mlc[`MLC_OUT2];

    always_comb begin
        logic par_x;
        par_x = 1'b0;
        nxt_s = s_ff;
        nxt_s.mst_prev = ms_now;
        // A change arriving with a read keeps its flag: set wins over clear.
        nxt_s.mst_delta = s_ff.mst_delta | ms_chg;

        if (setup) begin
            nxt_s.prdata = 32'h0000_0000;
            if (paddr == `LF_OFF_DATA && dlab) begin
                nxt_s.prdata = {24'h00_0000, s_ff.div[7:0]};
            end else if (paddr == `LF_OFF_IEN) begin
                nxt_s.prdata = dlab ? {24'h00_0000, s_ff.div[15:8]} :
                                      {28'h000_0000, s_ff.ien};
            end else if (paddr == `LF_OFF_LFC) begin
                nxt_s.prdata = {24'h00_0000, s_ff.lfc};
            end else if (paddr == `LF_OFF_MLC) begin
                nxt_s.prdata = {24'h00_0000, s_ff.mlc};
            end else if (paddr == `LF_OFF_MST) begin
                nxt_s.prdata = {24'h00_0000, ms_now, s_ff.mst_delta};
                nxt_s.mst_shown = s_ff.mst_delta;
            end
        end

        if (access && pwrite) begin
            if (paddr == `LF_OFF_DATA) begin
                if (dlab) begin
                    nxt_s.div[7:0] = pwdata[7:0];
                end else begin
                    nxt_s.thr = pwdata[7:0];
                    nxt_s.thr_full = 1'b1;
                end
            end else if (paddr == `LF_OFF_IEN) begin
                if (dlab) begin
                    nxt_s.div[15:8] = pwdata[7:0];
                end else begin
                    nxt_s.ien = pwdata[3:0];
                end
            end else if (paddr == `LF_OFF_LFC) begin
                nxt_s.lfc = pwdata[7:0];
            end else if (paddr == `LF_OFF_MLC) begin
                nxt_s.mlc = pwdata[7:0] & `MLC_USED_MASK;
            end
        end
        if (access && !pwrite && paddr == `LF_OFF_MST) begin
            nxt_s.mst_delta = (s_ff.mst_delta & ~s_ff.mst_shown) | ms_chg;
        end

        if (tick || s_ff.div == 16'h0000) begin
            nxt_s.baud_cnt = 16'h0000;
        end else begin
            nxt_s.baud_cnt = s_ff.baud_cnt + 16'h0001;
        end
        if (tick) begin
            nxt_s.sub = s_ff.sub + 5'h01;
        end

        unique case (s_ff.state)
            TX_IDLE: begin
                nxt_s.tx_bit = 1'b1;
                nxt_s.sub = 5'h00;
                if (tick && s_ff.thr_full) begin
                    par_x = ^(s_ff.thr & wmask);
                    if (s_ff.lfc[`LFC_STICK]) begin
                        nxt_s.par = ~s_ff.lfc[`LFC_EVEN];
                    end else begin
                        nxt_s.par = s_ff.lfc[`LFC_EVEN] ? par_x : ~par_x;
                    end
                    nxt_s.shift = s_ff.thr & wmask;
                    // A character written in this very cycle keeps the holding flag set.
                    if (!(access && pwrite && paddr == `LF_OFF_DATA && !dlab)) begin
                        nxt_s.thr_full = 1'b0;
                    end
                    nxt_s.tx_bit = 1'b0;
                    nxt_s.state = TX_START;
                end
            end
            TX_START: begin
                if (bit_end) begin
                    nxt_s.sub = 5'h00;
                    nxt_s.bit_idx = 3'h0;
                    nxt_s.tx_bit = s_ff.shift[0];
                    nxt_s.state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (bit_end) begin
                    nxt_s.sub = 5'h00;
                    if (s_ff.bit_idx == wl_last) begin
                        if (s_ff.lfc[`LFC_PAREN]) begin
                            nxt_s.tx_bit = s_ff.par;
                            nxt_s.state = TX_PARITY;
                        end else begin
                            nxt_s.tx_bit = 1'b1;
                            nxt_s.state = TX_STOP;
                        end
                    end else begin
                        nxt_s.shift = s_ff.shift >> 1;
                        nxt_s.tx_bit = s_ff.shift[1];
                        nxt_s.bit_idx = s_ff.bit_idx + 3'h1;
                    end
                end
            end
            TX_PARITY: begin
                if (bit_end) begin
                    nxt_s.sub = 5'h00;
                    nxt_s.tx_bit = 1'b1;
                    nxt_s.state = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tick && s_ff.sub == stop_last) begin
                    nxt_s.sub = 5'h00;
                    nxt_s.state = TX_IDLE;
                end
            end
            default: begin
                nxt_s.state = TX_IDLE;
                nxt_s.tx_bit = 1'b1;
            end
        endcase
    end

    // Everything freezes while the clock enable is low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '{lfc: `LFC_RESET, mlc: `MLC_RESET, ien: `IEN_RESET,
                      div: `DIV_RESET, thr: 8'h00, thr_full: 1'b0, state: TX_IDLE,
                      shift: 8'h00, bit_idx: 3'h0, sub: 5'h00, baud_cnt: 16'h0000,
                      par: 1'b0, tx_bit: 1'b1, mst_prev: 4'h0, mst_delta: 4'h0,
                      mst_shown: 4'h0, prdata: 32'h0000_0000};
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    property p_break_low;
        @(posedge pclk) disable iff (!presetn)
        s_ff.lfc[`LFC_BREAK] && !s_ff.mlc[`MLC_LOOP] |-> !tx_pin;
    endproperty
    a_break_low:
        assert property (p_break_low) else $error("Break set but tx pin not low.");

    property p_loop_tx_idle;
        @(posedge pclk) disable iff (!presetn)
        s_ff.mlc[`MLC_LOOP] |-> tx_pin && rts_n && dtr_n && rx_line == rt.tx_int;
    endproperty
    a_loop_tx_idle:
        assert property (p_loop_tx_idle) else $error("Loop-back pin routing wrong.");

    property p_loop_status;
        @(posedge pclk) disable iff (!presetn)
        s_ff.mlc[`MLC_LOOP] |-> ms_now == {s_ff.mlc[`MLC_OUT2], s_ff.mlc[`MLC_OUT1],
                                           s_ff.mlc[`MLC_DTR], s_ff.mlc[`MLC_RTS]};
    endproperty
    a_loop_status:
        assert property (p_loop_status) else $error("Loop-back status not from control bits.");

    property p_out2_irq;
        @(posedge pclk) disable iff (!presetn)
        irq_oe == s_ff.mlc[`MLC_OUT2] && (rt.loop || out2_n == !irq_oe);
    endproperty
    a_out2_irq:
        assert property (p_out2_irq) else $error("Second user output and irq enable disagree.");

    property p_unused_zero;
        @(posedge pclk) disable iff (!presetn)
        s_ff.mlc[7:5] == 3'b000;
    endproperty
    a_unused_zero:
        assert property (p_unused_zero) else $error("Unused modem-control bits set.");

    property p_div_write;
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && paddr == `LF_OFF_DATA && dlab
        |=> s_ff.div[7:0] == $past(pwdata[7:0]) && $stable(s_ff.thr_full);
    endproperty
    a_div_write:
        assert property (p_div_write) else $error("Divisor low write not taken.");

    property p_stop_long;
        @(posedge pclk) disable iff (!presetn)
        s_ff.state == TX_STOP && s_ff.sub > `TICK_BIT_LAST |-> s_ff.lfc[`LFC_STOP];
    endproperty
    a_stop_long:
        assert property (p_stop_long) else $error("Long stop without stop bit set.");

    property p_mstat_irq;
        @(posedge pclk) disable iff (!presetn)
        s_ff.ien[`IEN_MSTAT] && s_ff.mst_delta != 4'h0 |-> irq;
    endproperty
    a_mstat_irq:
        assert property (p_mstat_irq) else $error("Modem status interrupt missing.");

    property p_ien_write;
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && paddr == `LF_OFF_IEN && !dlab
        |=> s_ff.ien == $past(pwdata[3:0]) && $stable(s_ff.div);
    endproperty
    a_ien_write:
        assert property (p_ien_write) else $error("Interrupt enable write misrouted.");

    property p_lfc_write;
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && paddr == `LF_OFF_LFC |=> s_ff.lfc == $past(pwdata[7:0]);
    endproperty
    a_lfc_write:
        assert property (p_lfc_write) else $error("Line-format write not taken.");

    property p_mlc_write;
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && paddr == `LF_OFF_MLC
        |=> s_ff.mlc == ($past(pwdata[7:0]) & `MLC_USED_MASK);
    endproperty
    a_mlc_write:
        assert property (p_mlc_write) else $error("Modem-control write not taken.");

    property p_thr_write;
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && paddr == `LF_OFF_DATA && !dlab
        |=> s_ff.thr_full && s_ff.thr == $past(pwdata[7:0]) && $stable(s_ff.div);
    endproperty
    a_thr_write:
        assert property (p_thr_write) else $error("Holding write lost or misrouted.");

    property p_tx_start;
        @(posedge pclk) disable iff (!presetn)
        ce && s_ff.state == TX_IDLE && tick && s_ff.thr_full
        |=> s_ff.state == TX_START && !s_ff.tx_bit;
    endproperty
    a_tx_start:
        assert property (p_tx_start) else $error("Held character did not start a frame.");

endmodule : uart_line_format_loopback

`default_nettype wire

// ==== tb/remote_modem.sv ====
// Far-side model: a remote transceiver driving receive data and modem lines,
// and recording the transmit line. Assumes pclk is the bench clock.
`timescale 1ns/1ps
`default_nettype none

module remote_modem (
    // Bench control.
    input wire logic pclk,
    input wire logic arm,
    input wire logic [3:0] mdm_on,
    input wire logic rx_drive,
    output logic [255:0] hist,
    output logic done,
    // Line side.
    input wire logic tx_pin,
    output logic rx_pin,
    output logic cts_n,
    output logic dsr_n,
    output logic ri_n,
    output logic cd_n
);
    // Modem lines are active low at the pins; mdm_on is {cd, ri, dsr, cts}.
    assign {cd_n, ri_n, dsr_n, cts_n} = ~mdm_on;
    assign rx_pin = rx_drive;

    // Once armed, records one line sample per cycle from the next start edge.
    initial begin
        done = 1'b0;
        hist = '0;
        forever begin
            @(posedge arm);
            done = 1'b0;
            @(negedge tx_pin);
            for (int i = 0; i < 256; i++) begin
                @(negedge pclk);
                hist[i] = tx_pin;
            end
            done = 1'b1;
        end
    end
endmodule : remote_modem

`default_nettype wire

// ==== tb/uart_line_format_loopback_test.sv ====
// Self-checking bench for the line-format and loop-back channel block.
// Assumes the map header, package, design and remote_modem are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "uart_lf_map.svh"

`define CHK(nm, ex, got) begin \
    compares++; \
    if ((got) !== (ex)) begin \
        n_mismatch++; \
        $display("BAD %s expected %0h seen %0h", nm, ex, got); \
    end \
end

module uart_line_format_loopback_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic rx_pin, cts_n, dsr_n, ri_n, cd_n, tx_pin, rts_n, dtr_n, out1_n, out2_n;
    logic irq, irq_oe, rx_line, arm, rx_drive, done;
    logic ce = 1'b1;
    logic [3:0] mdm_on;
    logic [255:0] hist;
    int n_mismatch = 0;
    int compares = 0;

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    uart_line_format_loopback dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .cts_n(cts_n), .dsr_n(dsr_n),
        .ri_n(ri_n), .cd_n(cd_n), .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n),
        .out1_n(out1_n), .out2_n(out2_n), .irq(irq), .irq_oe(irq_oe), .rx_line(rx_line));

    remote_modem far (.pclk(pclk), .arm(arm), .mdm_on(mdm_on), .rx_drive(rx_drive),
        .hist(hist), .done(done), .tx_pin(tx_pin), .rx_pin(rx_pin), .cts_n(cts_n),
        .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n));

    task automatic tally_and_finish;
        $display("Mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, wd, d, e);
        // Outputs launched by the write settle before the caller looks at them.
        @(posedge pclk);
    endtask : wr

    task automatic rdx(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h00000000, d, e);
    endtask : rdx

    task automatic t_reset;
        logic [31:0] d;
        rdx(`LF_OFF_LFC, d);
        `CHK("format reset", 32'h00000000, d)
        rdx(`LF_OFF_MLC, d);
        `CHK("modem reset", 32'h00000000, d)
        `CHK("idle pins", 6'h3E, {tx_pin, rts_n, dtr_n, out1_n, out2_n, irq_oe})
    endtask : t_reset

    task automatic t_divisor;
        logic [31:0] d;
        logic e;
        wr(`LF_OFF_IEN, 32'h0000000A);
        wr(`LF_OFF_LFC, 32'h00000080);
        wr(`LF_OFF_DATA, 32'h00000001);
        wr(`LF_OFF_IEN, 32'h00000000);
        rdx(`LF_OFF_DATA, d);
        `CHK("divisor low", 32'h00000001, d)
        rdx(`LF_OFF_IEN, d);
        `CHK("divisor high", 32'h00000000, d)
        wr(`LF_OFF_LFC, 32'h00000003);
        rdx(`LF_OFF_IEN, d);
        `CHK("enables kept", 32'h0000000A, d)
        rdx(`LF_OFF_DATA, d);
        `CHK("latch closed", 32'h00000000, d)
        apb(1'b0, 8'h08, 32'h00000000, d, e);
        `CHK("unmapped error", 1'b1, e)
        `CHK("unmapped data", 32'h00000000, d)
    endtask : t_divisor

    // Sends two frames per format and checks the first one and its length.
    task automatic t_frames;
        logic [47:0] cfgs = 48'h040D1A2F3B00;
        logic [47:0] dts = 48'hC53A6E9D0FB2;
        logic [7:0] c, dt, dm;
        logic [11:0] fr, smp, m;
        logic par;
        int n, p, stp, per, k;
        for (int i = 0; i < 6; i++) begin
            c = cfgs[47 - 8 * i -: 8];
            dt = dts[47 - 8 * i -: 8];
            n = 5 + c[1:0];
            p = c[3];
            stp = c[2] ? ((n == 5) ? 24 : 32) : 16;
            per = 16 * (1 + n + p) + stp;
            dm = dt & (8'hFF >> (8 - n));
            par = c[5] ? ~c[4] : (c[4] ? ^dm : ~^dm);
            fr = 12'hFFE;
            for (k = 0; k < n; k++) fr[k + 1] = dt[k];
            if (p == 1) fr[n + 1] = par;
            m = (12'h001 << (n + p + 2)) - 12'h001;
            wr(`LF_OFF_LFC, {24'h000000, c});
            arm <= 1'b1;
            wr(`LF_OFF_DATA, {24'h000000, dt});
            repeat (20) @(posedge pclk);
            wr(`LF_OFF_DATA, 32'h00000000);
            k = 0;
            while (done !== 1'b1 && k < 2000) begin
                @(posedge pclk);
                k++;
            end
            if (k >= 2000) n_mismatch++;
            if (k >= 2000) tally_and_finish();
            for (k = 0; k < 12; k++) smp[k] = hist[8 + 16 * k];
            `CHK("frame bits", fr & m, smp & m)
            `CHK("frame length", 2'b10, {hist[per - 4], hist[per + 4]})
            arm <= 1'b0;
            repeat (250) @(posedge pclk);
        end
    endtask : t_frames

    task automatic t_break;
        int bad;
        wr(`LF_OFF_LFC, 32'h00000043);
        bad = 0;
        repeat (40) begin
            @(negedge pclk);
            if (tx_pin !== 1'b0) bad++;
        end
        `CHK("break held", 0, bad)
        wr(`LF_OFF_LFC, 32'h00000003);
        repeat (2) @(posedge pclk);
        `CHK("break ended", 1'b1, tx_pin)
    endtask : t_break

    task automatic t_modem;
        logic [31:0] d;
        wr(`LF_OFF_MLC, 32'h0000000B);
        `CHK("modem outs", 6'h25, {tx_pin, rts_n, dtr_n, out1_n, out2_n, irq_oe})
        rdx(`LF_OFF_MST, d);
        `CHK("pin status", 4'hA, d[7:4])
        rx_drive <= 1'b0;
        wr(`LF_OFF_MLC, 32'h00000016);
        `CHK("loop pins", 6'h3E, {tx_pin, rts_n, dtr_n, out1_n, out2_n, irq_oe})
        rdx(`LF_OFF_MST, d);
        `CHK("loop status", 4'h5, d[7:4])
        `CHK("loop rx idle", 1'b1, rx_line)
        wr(`LF_OFF_LFC, 32'h00000043);
        repeat (2) @(posedge pclk);
        `CHK("loop break", 2'b01, {rx_line, tx_pin})
        wr(`LF_OFF_LFC, 32'h00000003);
        wr(`LF_OFF_IEN, 32'h00000008);
        rdx(`LF_OFF_MST, d);
        repeat (3) @(posedge pclk);
        `CHK("no delta", 1'b0, irq)
        wr(`LF_OFF_MLC, 32'h0000001E);
        repeat (3) @(posedge pclk);
        `CHK("loop delta irq", 2'b11, {irq, irq_oe})
        wr(`LF_OFF_IEN, 32'h00000000);
        `CHK("delta masked", 1'b0, irq)
        wr(`LF_OFF_IEN, 32'h00000002);
        `CHK("loop tx irq", 1'b1, irq)
        wr(`LF_OFF_MLC, 32'h000000FF);
        rdx(`LF_OFF_MLC, d);
        `CHK("unused bits", 32'h0000001F, d)
        wr(`LF_OFF_MLC, 32'h00000000);
        repeat (2) @(posedge pclk);
        `CHK("loop left", 1'b0, rx_line)
    endtask : t_modem

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        arm = 1'b0;
        rx_drive = 1'b1;
        mdm_on = 4'hA;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_divisor();
        t_frames();
        t_break();
        t_modem();
        tally_and_finish();
    end
endmodule : uart_line_format_loopback_test

`default_nettype wire
